/* rtl/acr_pkg.sv */
// acr_pkg: constants and types of the channel calibration register bank.
// assumes a 16-bit register port and 24-bit converter results.
package acr_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int CAL_W = 24;
    localparam int CHANNELS = 2;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] CHAN0_INPUT_CONFIG = 8'h09;
    localparam logic [7:0] CHAN0_OFFSET_CORR_HIGH = 8'h0a;
    localparam logic [7:0] CHAN0_OFFSET_CORR_LOW = 8'h0b;
    localparam logic [7:0] CHAN0_GAIN_CORR_HIGH = 8'h0c;
    localparam logic [7:0] CHAN0_GAIN_CORR_LOW = 8'h0d;
    localparam logic [7:0] CHAN1_INPUT_CONFIG = 8'h0e;
    localparam logic [7:0] CHAN1_OFFSET_CORR_HIGH = 8'h0f;
    localparam logic [1:0][7:0] CFG_OFF = {CHAN1_INPUT_CONFIG,
                                           CHAN0_INPUT_CONFIG};

    // ----------------------------------------------------------------
    // reset values and field layout
    // ----------------------------------------------------------------
    localparam logic [15:0] CFG_RST = 16'h0000;
    localparam logic [15:0] OFFSET_HIGH_RST = 16'h0000;
    localparam logic [7:0] OFFSET_LOW_RST = 8'h00;
    localparam logic [15:0] GAIN_HIGH_RST = 16'h8000;
    localparam logic [7:0] GAIN_LOW_RST = 8'h00;
    // bits 5:3 of a config word are read-only zero
    localparam logic [15:0] CFG_WR_MASK = 16'hffc7;
    localparam int SEL_LSB = 0;
    localparam int LOW_FIELD_LSB = 8;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SEL_PINS = 2'b00,
        SEL_SHORT = 2'b01,
        SEL_TEST_POS = 2'b10,
        SEL_TEST_NEG = 2'b11
    } acr_sel_t;

    // one-hot switch controls of a channel's analog input network
    typedef struct packed {
        logic pins;
        logic shorted;
        logic test_pos;
        logic test_neg;
    } acr_route_t;

    localparam acr_route_t ROUTE_RST = 4'b1000;

endpackage

/* rtl/acr_corrector.sv */
// acr_corrector: two-stage offset and gain correction of a raw result.
// assumes raw results arrive on ref_clk with a one-cycle valid strobe.
`timescale 1ns/1ps
module acr_corrector import acr_pkg::*; #(
    parameter int W = CAL_W
) (
    input wire logic ref_clk, // system clock
    input wire logic nrst, // async reset, active low
    input wire logic raw_valid, // raw result strobe
    input wire logic [W-1:0] raw, // raw signed result
    input wire logic [W-1:0] offset, // signed offset correction
    input wire logic [W-1:0] gain, // unsigned gain, 1.0 at 2^(W-1)
    output logic out_valid, // corrected result strobe
    output logic [W-1:0] result // corrected signed result
);

    // ----------------------------------------------------------------
    // stage 1: offset removal
    // ----------------------------------------------------------------
    logic signed [W:0] diff;
    logic diff_vld;
    logic [W-1:0] gain_q;
    wire signed [W:0] next_diff = $signed({raw[W-1], raw}) -
                                  $signed({offset[W-1], offset});

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            diff <= '0;
            diff_vld <= 1'b0;
            gain_q <= '0;
        end else begin
            diff_vld <= raw_valid;
            if (raw_valid) begin
                diff <= next_diff;
                gain_q <= gain;
            end
        end
    end

    // ----------------------------------------------------------------
    // stage 2: gain, rescale and saturate
    // ----------------------------------------------------------------
    wire signed [2*W+1:0] prod = diff * $signed({1'b0, gain_q});
    wire signed [W+2:0] scaled = prod[2*W+1:W-1];
    wire fits = (scaled[W+2:W-1] == '0) || (scaled[W+2:W-1] == '1);
    wire [W-1:0] sat_val = scaled[W+2] ? {1'b1, {(W-1){1'b0}}} :
                                         {1'b0, {(W-1){1'b1}}};
    wire [W-1:0] next_result = fits ? scaled[W-1:0] : sat_val;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            out_valid <= 1'b0;
            result <= '0;
        end else begin
            out_valid <= diff_vld;
            if (diff_vld) begin
                result <= next_result;
            end
        end
    end

endmodule

/* rtl/acr_cal_regs.sv */
// acr_cal_regs: per-channel input selection, channel 0 calibration and channel 1 offset high registers,
// input routing controls and the channel 0 result correction.
// assumes a synchronous register port on ref_clk and converter results
// produced by logic on the same clock.
`timescale 1ns/1ps

module acr_cal_regs import acr_pkg::*; (
    input wire logic ref_clk, // 20 MHz system clock
    input wire logic nrst, // async reset, active low
    input wire logic [ADDR_W-1:0] reg_addr, // register offset
    input wire logic [DATA_W-1:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [DATA_W-1:0] reg_rdata, // read data, cycle after strobe
    output acr_route_t chan0_route, // channel 0 input switches
    output acr_route_t chan1_route, // channel 1 input switches
    input wire logic conv_valid, // channel 0 raw result strobe
    input wire logic [CAL_W-1:0] conv_result, // channel 0 raw result
    output logic corr_valid, // corrected result strobe
    output logic [CAL_W-1:0] corr_result // corrected result
);

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] cfg [CHANNELS];
    logic [DATA_W-1:0] chan0_offset_high_field;
    logic [7:0] chan0_offset_low_field;
    logic [DATA_W-1:0] chan0_gain_high_field;
    logic [7:0] chan0_gain_low_field;
    logic [DATA_W-1:0] chan1_offset_high_field;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    wire hit_off0_hi = (reg_addr == CHAN0_OFFSET_CORR_HIGH);
    wire hit_off0_lo = (reg_addr == CHAN0_OFFSET_CORR_LOW);
    wire hit_gain0_hi = (reg_addr == CHAN0_GAIN_CORR_HIGH);
    wire hit_gain0_lo = (reg_addr == CHAN0_GAIN_CORR_LOW);
    wire hit_off1_hi = (reg_addr == CHAN1_OFFSET_CORR_HIGH);
    wire [CHANNELS-1:0] hit_cfg;

    wire wr_off0_hi = reg_wr && hit_off0_hi;
    wire wr_off0_lo = reg_wr && hit_off0_lo;
    wire wr_gain0_hi = reg_wr && hit_gain0_hi;
    wire wr_gain0_lo = reg_wr && hit_gain0_lo;
    wire wr_off1_hi = reg_wr && hit_off1_hi;

    // ----------------------------------------------------------------
    // per-channel config and input routing
    // ----------------------------------------------------------------
    acr_route_t route [CHANNELS];
    acr_route_t [CHANNELS-1:0] next_route;

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
            wire acr_sel_t sel = acr_sel_t'(cfg[ch][SEL_LSB +: 2]);

            assign hit_cfg[ch] = (reg_addr == CFG_OFF[ch]);

            // switch controls follow the stored selector
            assign next_route[ch].pins = (sel == SEL_PINS);
            assign next_route[ch].shorted = (sel == SEL_SHORT);
            assign next_route[ch].test_pos = (sel == SEL_TEST_POS);
            assign next_route[ch].test_neg = (sel == SEL_TEST_NEG);

            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    cfg[ch] <= CFG_RST;
                end else if (reg_wr && hit_cfg[ch]) begin
                    // reserved read-write bits are kept as written
                    cfg[ch] <= reg_wdata & CFG_WR_MASK;
                end
            end

            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    route[ch] <= ROUTE_RST;
                end else begin
                    route[ch] <= next_route[ch];
                end
            end
        end
    endgenerate

    assign chan0_route = route[0];
    assign chan1_route = route[1];

    // ----------------------------------------------------------------
    // channel 0 offset correction
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            chan0_offset_high_field <= OFFSET_HIGH_RST;
        end else if (wr_off0_hi) begin
            chan0_offset_high_field <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            chan0_offset_low_field <= OFFSET_LOW_RST;
        end else if (wr_off0_lo) begin
            // low byte of the word is read-only and not stored
            chan0_offset_low_field <= reg_wdata[LOW_FIELD_LSB +: 8];
        end
    end

    // ----------------------------------------------------------------
    // channel 0 gain correction
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            chan0_gain_high_field <= GAIN_HIGH_RST;
        end else if (wr_gain0_hi) begin
            chan0_gain_high_field <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            chan0_gain_low_field <= GAIN_LOW_RST;
        end else if (wr_gain0_lo) begin
            chan0_gain_low_field <= reg_wdata[LOW_FIELD_LSB +: 8];
        end
    end

    // ----------------------------------------------------------------
    // channel 1 offset correction, upper half
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            chan1_offset_high_field <= OFFSET_HIGH_RST;
        end else if (wr_off1_hi) begin
            chan1_offset_high_field <= reg_wdata;
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    wire [DATA_W-1:0] rd_cfg0 = cfg[0]; // bits 5:3 never stored
    wire [DATA_W-1:0] rd_cfg1 = cfg[1];
    wire [DATA_W-1:0] rd_off0_lo = {chan0_offset_low_field,
                                    8'h00};
    wire [DATA_W-1:0] rd_gain0_lo = {chan0_gain_low_field,
                                     8'h00};

    logic [DATA_W-1:0] rd_mux;

    always_comb begin
        rd_mux = '0;
        case (reg_addr)
            CHAN0_INPUT_CONFIG: begin
                rd_mux = rd_cfg0;
            end
            CHAN0_OFFSET_CORR_HIGH: begin
                rd_mux = chan0_offset_high_field;
            end
            CHAN0_OFFSET_CORR_LOW: begin
                rd_mux = rd_off0_lo;
            end
            CHAN0_GAIN_CORR_HIGH: begin
                rd_mux = chan0_gain_high_field;
            end
            CHAN0_GAIN_CORR_LOW: begin
                rd_mux = rd_gain0_lo;
            end
            CHAN1_INPUT_CONFIG: begin
                rd_mux = rd_cfg1;
            end
            CHAN1_OFFSET_CORR_HIGH: begin
                rd_mux = chan1_offset_high_field;
            end
            default: begin
                // unmapped offsets read as zero
                rd_mux = '0;
            end
        endcase
    end

    // data stands only in the cycle after the read strobe
    wire [DATA_W-1:0] next_rdata = reg_rd ? rd_mux : '0;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // channel 0 result correction
    // ----------------------------------------------------------------
    wire [CAL_W-1:0] chan0_offset = {chan0_offset_high_field,
                                     chan0_offset_low_field};
    wire [CAL_W-1:0] chan0_gain = {chan0_gain_high_field,
                                   chan0_gain_low_field};

    acr_corrector #(
        .W(CAL_W)
    ) u_corr (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .raw_valid(conv_valid),
        .raw(conv_result),
        .offset(chan0_offset),
        .gain(chan0_gain),
        .out_valid(corr_valid),
        .result(corr_result)
    );

endmodule

/* dv/acr_cal_regs_monitor.sv */
// acr_cal_regs_monitor: port-level checks of the calibration register bank.
// assumes the single ref_clk domain with nrst as its async reset.
`timescale 1ns/1ps
module acr_cal_regs_monitor import acr_pkg::*; (
    input wire logic ref_clk, // system clock
    input wire logic nrst, // async reset, active low
    input wire logic [ADDR_W-1:0] reg_addr, // register offset
    input wire logic [DATA_W-1:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [DATA_W-1:0] reg_rdata, // read data
    input wire acr_route_t chan0_route, // channel 0 switches
    input wire acr_route_t chan1_route, // channel 1 switches
    input wire logic conv_valid, // raw result strobe
    input wire logic [CAL_W-1:0] conv_result, // raw result
    input wire logic corr_valid, // corrected strobe
    input wire logic [CAL_W-1:0] corr_result // corrected result
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    cfg_ro_bits_a: assert property (reg_rd && reg_addr == CHAN0_INPUT_CONFIG
        |=> reg_rdata[5:3] == 3'h0) else $error("config bits 5:3 not zero");
    olow_ro_a: assert property (reg_rd && reg_addr == CHAN0_OFFSET_CORR_LOW
        |=> reg_rdata[7:0] == 8'h00) else $error("offset low byte not zero");
    glow_ro_a: assert property (reg_rd && reg_addr == CHAN0_GAIN_CORR_LOW
        |=> reg_rdata[7:0] == 8'h00) else $error("gain low byte not zero");
    ohigh_rb_a: assert property (reg_wr && reg_addr == CHAN0_OFFSET_CORR_HIGH
        ##2 reg_rd && reg_addr == CHAN0_OFFSET_CORR_HIGH
        |=> reg_rdata == $past(reg_wdata, 3)) else $error("offset high lost");
    ghigh_rb_a: assert property (reg_wr && reg_addr == CHAN0_GAIN_CORR_HIGH
        ##2 reg_rd && reg_addr == CHAN0_GAIN_CORR_HIGH
        |=> reg_rdata == $past(reg_wdata, 3)) else $error("gain high lost");

    // ----------------------------------------------------------------
    // input routing and correction
    // ----------------------------------------------------------------
    route_hot_a: assert property ($onehot(chan0_route)
        && $onehot(chan1_route)) else $error("route not one-hot");
    route_short_a: assert property (reg_wr && reg_addr == CHAN0_INPUT_CONFIG
        && reg_wdata[1:0] == 2'b01 |-> ##2 chan0_route == 4'b0100)
        else $error("short route missing");
    route_test_a: assert property (reg_wr && reg_addr == CHAN0_INPUT_CONFIG
        && reg_wdata[1] |-> ##2 !chan0_route.pins && !chan0_route.shorted
        && chan0_route.test_neg == $past(reg_wdata[0], 2))
        else $error("test signal route wrong");
    route1_pins_a: assert property (reg_wr && reg_addr == CHAN1_INPUT_CONFIG
        && reg_wdata[1:0] == 2'b00 |-> ##2 chan1_route == 4'b1000)
        else $error("channel 1 pins route wrong");
    corr_lat_a: assert property (conv_valid |-> ##2 corr_valid)
        else $error("corrected strobe late");
endmodule

bind acr_cal_regs acr_cal_regs_monitor mon (.ref_clk(ref_clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chan0_route(chan0_route),
    .chan1_route(chan1_route), .conv_valid(conv_valid),
    .conv_result(conv_result), .corr_valid(corr_valid),
    .corr_result(corr_result));

/* dv/tb_acr_cal_regs.sv */
// tb_acr_cal_regs: register, routing and correction tests of acr_cal_regs.
// assumes the monitor is bound in and a 20 MHz ref_clk.
`timescale 1ns/1ps
module tb_acr_cal_regs import acr_pkg::*;;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    acr_route_t chan0_route;
    acr_route_t chan1_route;
    logic conv_valid = 1'b0;
    logic [23:0] conv_result = 24'h000000;
    logic corr_valid;
    logic [23:0] corr_result;
    int err_count = 0;
    int checked = 0;
    logic [7:0] ad [9] = '{8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f,
                           8'h10, 8'h00};
    logic [15:0] rv [9] = '{16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000,
                            16'h0000, 16'h0000, 16'h0000, 16'h0000};
    // config writes keep reserved read-write bits zero, set read-only 5:3
    logic [15:0] wd [9] = '{16'h003b, 16'hffff, 16'hffff, 16'hffff, 16'hffff,
                            16'h003b, 16'hffff, 16'hffff, 16'hffff};
    logic [15:0] wv [9] = '{16'h0003, 16'hffff, 16'hff00, 16'hffff, 16'hff00,
                            16'h0003, 16'hffff, 16'h0000, 16'h0000};

    acr_cal_regs dut (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .chan0_route(chan0_route),
        .chan1_route(chan1_route), .conv_valid(conv_valid),
        .conv_result(conv_result), .corr_valid(corr_valid),
        .corr_result(corr_result));

    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    // ----------------------------------------------------------------
    // access and compare tasks
    // ----------------------------------------------------------------
    task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_out(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        chk_reg(reg_rdata, exp);
    endtask

    // corrected strobe stands between the first and second edges after
    // the taking edge
    task automatic conv(input logic [23:0] raw, input logic [23:0] exp);
        @(posedge ref_clk);
        conv_valid <= 1'b1;
        conv_result <= raw;
        @(posedge ref_clk);
        conv_valid <= 1'b0;
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk_out({23'h0, corr_valid}, 24'h000001);
        chk_out(corr_result, exp);
    endtask

    task automatic do_reset();
        @(posedge ref_clk);
        nrst <= 1'b0;
        repeat (10) @(posedge ref_clk);
        nrst <= 1'b1;
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        err_count++;
        close_out();
    end

    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial begin
        do_reset();
        chk_out({20'h0, chan0_route}, 24'h000008);
        for (int i = 0; i < 9; i++) begin
            rd(ad[i], rv[i]);
        end
        $display("test reset values done");
        for (int i = 0; i < 9; i++) begin
            wr(ad[i], wd[i]);
            rd(ad[i], wv[i]);
        end
        $display("test read-only bits done");
        for (int s = 0; s < 4; s++) begin
            wr(CHAN0_INPUT_CONFIG, 16'(s));
            wr(CHAN1_INPUT_CONFIG, 16'(3 - s));
            // routes follow the stored selector one edge later
            @(posedge ref_clk);
            @(negedge ref_clk);
            chk_out({20'h0, chan0_route}, 24'(4'b1000 >> s));
            chk_out({20'h0, chan1_route}, 24'(4'b0001 << s));
        end
        $display("test input selection done");
        do_reset();
        conv(24'h000100, 24'h000100);
        wr(CHAN0_OFFSET_CORR_HIGH, 16'hffff);
        wr(CHAN0_OFFSET_CORR_LOW, 16'hf000);
        conv(24'h000100, 24'h000110);
        wr(CHAN0_GAIN_CORR_HIGH, 16'h4000);
        conv(24'h000100, 24'h000088);
        conv(24'h800000, 24'hc00008);
        wr(CHAN0_GAIN_CORR_HIGH, 16'hffff);
        wr(CHAN0_GAIN_CORR_LOW, 16'hffff);
        conv(24'h7fff00, 24'h7fffff);
        $display("test correction done");
        close_out();
    end
endmodule
